// ==== design/msr_map.vh ====
`ifndef MSR_MAP_VH
`define MSR_MAP_VH
// Register byte offsets
`define MSR_REG_CTRL 4'h0
`define MSR_REG_STATUS 4'h4
`define MSR_REG_MASK 4'h8
`define MSR_REG_PKT 4'hC
// Control fields
`define MSR_CTRL_EN 0
`define MSR_CTRL_RESET_VAL 1'b1
// Status / mask fields
`define MSR_ST_PKT 0
`define MSR_ST_PAR 1
`define MSR_ST_FRM 2
`define MSR_ST_W 3
// Packet byte 1 fields
`define MSR_B1_LEFT 0
`define MSR_B1_RIGHT 1
`define MSR_B1_ZERO 2
`define MSR_B1_ONE 3
`define MSR_B1_XSIGN 4
`define MSR_B1_YSIGN 5
`define MSR_B1_XOVF 6
`define MSR_B1_YOVF 7
// Frame layout: start, 8 data, parity, stop
`define MSR_FRAME_BITS 4'hB
`define MSR_IDX_PAR 4'h9
`define MSR_IDX_STOP 4'hA
// Frame timeout: 50 us period bound, two periods of silence restart framing
`define MSR_TMO_NS 100000
`define MSR_CLK_NS 4
`endif

// ==== design/msr_sync.v ====
`timescale 1ns/1ps
`default_nettype none
module msr_sync #(
   parameter W = 2
) (
   input wire clk_i,
   input wire rst_i,
   input wire [W-1:0] async_i,
   output reg [W-1:0] sync_o
);
   reg [W-1:0] meta;
   // Two-stage synchroniser; meta is read only by sync_o
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta <= {W{1'b1}};
         sync_o <= {W{1'b1}};
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule
`default_nettype wire

// ==== design/msr_frame.v ====
`timescale 1ns/1ps
`default_nettype none
`include "msr_map.vh"
module msr_frame #(
   parameter TMO_CYC = 25000
) (
   input wire clk_i,
   input wire rst_i,
   input wire en_i,
   input wire kclk_i,
   input wire kdat_i,
   output reg byte_vld_o,
   output reg [7:0] byte_o,
   output reg par_err_o,
   output reg frm_err_o
);
   reg kclk_d;
   reg [3:0] bit_cnt;
   reg [9:0] shreg;
   reg [31:0] idle_cnt;
   wire fall;
   wire odd_ok;
   assign fall = kclk_d & ~kclk_i;
   // Odd count of ones over data and parity, valid at the stop edge
   assign odd_ok = ^shreg[9:1];
   // Sample data at every falling clock edge while enabled, shift in LSB first
   always @(posedge clk_i) begin
      if (rst_i) begin
         kclk_d <= 1'b1;
         bit_cnt <= 4'h0;
         shreg <= 10'h000;
         idle_cnt <= 32'h0;
         byte_vld_o <= 1'b0;
         byte_o <= 8'h00;
         par_err_o <= 1'b0;
         frm_err_o <= 1'b0;
      end else begin
         kclk_d <= kclk_i;
         byte_vld_o <= 1'b0;
         par_err_o <= 1'b0;
         frm_err_o <= 1'b0;
         if (fall)
            idle_cnt <= 32'h0;
         else if (idle_cnt != TMO_CYC)
            idle_cnt <= idle_cnt + 32'h1;
         // A stalled frame is dropped so the next start bit realigns
         if (!en_i || (idle_cnt == TMO_CYC && !fall)) begin
            bit_cnt <= 4'h0;
         end else if (fall) begin
            shreg <= {kdat_i, shreg[9:1]};
            if (bit_cnt == 4'h0) begin
               // A high start bit is line noise; stay idle
               if (!kdat_i)
                  bit_cnt <= 4'h1;
            end else if (bit_cnt == `MSR_IDX_STOP) begin
               bit_cnt <= 4'h0;
               if (!kdat_i) begin
                  frm_err_o <= 1'b1;
               end else if (!odd_ok) begin
                  par_err_o <= 1'b1;
               end else begin
                  byte_vld_o <= 1'b1;
                  byte_o <= shreg[8:1];
               end
            end else begin
               bit_cnt <= bit_cnt + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== design/msr_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "msr_map.vh"
// What this block does
// - Frame is start, eight data bits LSB first, parity, stop.
// - Parity makes ones over data plus parity odd; receiver checks it.
// - Start bit low, stop bit high; bad stop bit means malformed frame.
// - Byte 2 is X magnitude, byte 3 is Y magnitude, LSB in bit 0.
// - A button reads pressed when its first-byte bit is one.
// - A sign bit of one means negative movement on that axis.
// - An overflow bit of one means the magnitude byte was exceeded.
// - Right and up positive, left and down negative in displacement.
module msr_top #(
   parameter TMO_NS = `MSR_TMO_NS,
   parameter TMO_CYC = `MSR_TMO_NS / `MSR_CLK_NS
) (
   input wire clk_i,
   input wire rst_i,
   input wire ms_clk_i,
   input wire ms_data_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg irq_o,
   output reg pkt_vld_o,
   output reg left_btn_o,
   output reg right_btn_o,
   output reg x_sign_o,
   output reg y_sign_o,
   output reg x_overflow_o,
   output reg y_overflow_o,
   output reg [7:0] x_magnitude_o,
   output reg [7:0] y_magnitude_o,
   output reg [8:0] x_disp_o,
   output reg [8:0] y_disp_o,
   output reg err_o
);
   localparam ST_B1 = 2'h0;
   localparam ST_B2 = 2'h1;
   localparam ST_B3 = 2'h2;

   wire [1:0] line_s;
   wire byte_vld;
   wire [7:0] rx_byte;
   wire par_err;
   wire frm_err;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [7:0] hold1;
   reg [7:0] hold2;
   reg pkt_done;
   reg ctrl_en;
   reg [`MSR_ST_W-1:0] status;
   reg [`MSR_ST_W-1:0] mask;
   reg [`MSR_ST_W-1:0] ev;
   reg [31:0] rd_mux;
   wire wb_req;
   wire wb_wr;
   wire [`MSR_ST_W-1:0] w1c;

   // Idle level of the serial clock is high, so the sync resets high
   msr_sync #(.W(2)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({ms_clk_i, ms_data_i}),
      .sync_o(line_s)
   );

   // Period and setup bounds are the mouse's; timeout spans two long periods
   msr_frame #(.TMO_CYC(TMO_CYC)) u_frame (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(ctrl_en),
      .kclk_i(line_s[1]),
      .kdat_i(line_s[0]),
      .byte_vld_o(byte_vld),
      .byte_o(rx_byte),
      .par_err_o(par_err),
      .frm_err_o(frm_err)
   );

   // Packet assembly sequence
   always @* begin
      next_state = state;
      if (byte_vld) begin
         case (state)
            ST_B1: begin
               // Bit 3 is always one; a byte without it cannot start a packet
               if (rx_byte[`MSR_B1_ONE])
                  next_state = ST_B2;
            end
            ST_B2: next_state = ST_B3;
            ST_B3: next_state = ST_B1;
            default: next_state = ST_B1;
         endcase
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_B1;
         hold1 <= 8'h00;
         hold2 <= 8'h00;
         pkt_done <= 1'b0;
      end else begin
         pkt_done <= 1'b0;
         if (!ctrl_en) begin
            state <= ST_B1;
         end else if (par_err || frm_err) begin
            // A lost byte breaks alignment; restart at the first byte
            state <= ST_B1;
         end else begin
            state <= next_state;
            if (byte_vld && state == ST_B1)
               hold1 <= rx_byte;
            if (byte_vld && state == ST_B2)
               hold2 <= rx_byte;
            if (byte_vld && state == ST_B3)
               pkt_done <= 1'b1;
         end
      end
   end

   // Decoded packet outputs, updated together when the third byte lands
   always @(posedge clk_i) begin
      if (rst_i) begin
         pkt_vld_o <= 1'b0;
         left_btn_o <= 1'b0;
         right_btn_o <= 1'b0;
         x_sign_o <= 1'b0;
         y_sign_o <= 1'b0;
         x_overflow_o <= 1'b0;
         y_overflow_o <= 1'b0;
         x_magnitude_o <= 8'h00;
         y_magnitude_o <= 8'h00;
         x_disp_o <= 9'h000;
         y_disp_o <= 9'h000;
         err_o <= 1'b0;
      end else begin
         pkt_vld_o <= 1'b0;
         err_o <= par_err | frm_err;
         if (byte_vld && state == ST_B3 && ctrl_en) begin
            pkt_vld_o <= 1'b1;
            left_btn_o <= hold1[`MSR_B1_LEFT];
            right_btn_o <= hold1[`MSR_B1_RIGHT];
            x_sign_o <= hold1[`MSR_B1_XSIGN];
            y_sign_o <= hold1[`MSR_B1_YSIGN];
            x_overflow_o <= hold1[`MSR_B1_XOVF];
            y_overflow_o <= hold1[`MSR_B1_YOVF];
            x_magnitude_o <= hold2;
            y_magnitude_o <= rx_byte;
            // Sign joins magnitude as nine-bit two's complement
            x_disp_o <= {hold1[`MSR_B1_XSIGN], hold2};
            y_disp_o <= {hold1[`MSR_B1_YSIGN], rx_byte};
         end
      end
   end

   // Events: packet ready, parity error, framing error
   always @* begin
      ev = {`MSR_ST_W{1'b0}};
      ev[`MSR_ST_PKT] = pkt_done;
      ev[`MSR_ST_PAR] = par_err;
      ev[`MSR_ST_FRM] = frm_err;
   end

   // Request taken while ack is low; a write lands on the edge where the
   // master samples ack, so it is applied exactly once per transfer
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
   assign w1c = (wb_wr && wb_adr_i == `MSR_REG_STATUS) ?
      wb_dat_i[`MSR_ST_W-1:0] : {`MSR_ST_W{1'b0}};

   // Read mux; unmapped addresses read zero
   always @* begin
      case (wb_adr_i)
         `MSR_REG_CTRL: rd_mux = {31'h0, ctrl_en};
         `MSR_REG_STATUS: rd_mux = {29'h0, status};
         `MSR_REG_MASK: rd_mux = {29'h0, mask};
         `MSR_REG_PKT: rd_mux = {8'h00, y_magnitude_o, x_magnitude_o,
            y_overflow_o, x_overflow_o, y_sign_o, x_sign_o, 1'b1, 1'b0,
            right_btn_o, left_btn_o};
         default: rd_mux = 32'h0;
      endcase
   end

   // Wishbone slave: one-cycle ack, ack drops the cycle after
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl_en <= `MSR_CTRL_RESET_VAL;
         mask <= {`MSR_ST_W{1'b0}};
         status <= {`MSR_ST_W{1'b0}};
         irq_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req)
            wb_dat_o <= rd_mux;
         if (wb_wr && wb_adr_i == `MSR_REG_CTRL)
            ctrl_en <= wb_dat_i[`MSR_CTRL_EN];
         if (wb_wr && wb_adr_i == `MSR_REG_MASK)
            mask <= wb_dat_i[`MSR_ST_W-1:0];
         // Set wins over write-one-to-clear in the same cycle
         status <= (status & ~w1c) | ev;
         irq_o <= |(((status & ~w1c) | ev) & mask);
      end
   end
endmodule
`default_nettype wire

// ==== verif/msr_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module msr_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic pkt_vld_o,
   input wire logic err_o,
   input wire logic left_btn_o,
   input wire logic x_sign_o,
   input wire logic y_sign_o,
   input wire logic [7:0] x_magnitude_o,
   input wire logic [7:0] y_magnitude_o,
   input wire logic [8:0] x_disp_o,
   input wire logic [8:0] y_disp_o
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_on_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not answered");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_pkt_single: assert property (pkt_vld_o |=> !pkt_vld_o)
      else $error("packet strobe too long");
   a_err_single: assert property (err_o |=> !err_o)
      else $error("error pulse too long");
   a_x_disp: assert property (x_disp_o == {x_sign_o, x_magnitude_o})
      else $error("x displacement wrong");
   a_y_disp: assert property (y_disp_o == {y_sign_o, y_magnitude_o})
      else $error("y displacement wrong");
   a_fields_hold: assert property (!pkt_vld_o |->
      $stable(x_magnitude_o) && $stable(y_magnitude_o)
      && $stable(left_btn_o))
      else $error("packet fields moved without strobe");
endmodule
bind msr_top msr_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .pkt_vld_o, .err_o, .left_btn_o, .x_sign_o, .y_sign_o,
   .x_magnitude_o, .y_magnitude_o, .x_disp_o, .y_disp_o);
`default_nettype wire

// ==== verif/msr_mouse.sv ====
`timescale 1ns/1ps
`default_nettype none
module msr_mouse (
   output logic ms_clk_o,
   output logic ms_data_o
);
   // Serial clock rests high between frames
   initial begin
      ms_clk_o = 1'b1;
      ms_data_o = 1'b1;
   end
   // Byte handed in goes out as one frame; bp flips parity, bs spoils the stop bit
   task automatic send(input logic [7:0] b, input logic bp, input logic bs);
      logic [10:0] f;
      f = {~bs, (~^b) ^ bp, b, 1'b0};
      #1.3;
      // Data moves mid-high, well before the falling edge, 48 ns period
      for (int i = 0; i < 11; i++) begin
         ms_data_o = f[i];
         #12 ms_clk_o = 1'b0;
         #24 ms_clk_o = 1'b1;
         #12;
      end
      ms_data_o = ~f[10]; // Released line must not keep the last value
      #200;
   endtask
endmodule
`default_nettype wire

// ==== verif/tb_mouse_serial_packet_receiver.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_mouse_serial_packet_receiver;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [3:0] adr = 0;
   logic [31:0] wdat = 0, rdat, q;
   logic ms_clk, ms_data, ack, irq, vld, lb, rb, xs, ys, xo, yo, err;
   logic [7:0] xm, ym;
   logic [8:0] xd, yd;
   int n_fail = 0, checked = 0, n_pkt = 0, n_err = 0;
   msr_top #(.TMO_CYC(100)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .ms_clk_i(ms_clk), .ms_data_i(ms_data), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
      .pkt_vld_o(vld), .left_btn_o(lb), .right_btn_o(rb), .x_sign_o(xs),
      .y_sign_o(ys), .x_overflow_o(xo), .y_overflow_o(yo),
      .x_magnitude_o(xm), .y_magnitude_o(ym), .x_disp_o(xd),
      .y_disp_o(yd), .err_o(err));
   msr_mouse u_mouse (.ms_clk_o(ms_clk), .ms_data_o(ms_data));
   initial forever #2 clk_i = ~clk_i;
   // Pulses are counted here since they fire while the mouse still talks
   always @(posedge clk_i) begin
      if (vld === 1'b1) n_pkt++;
      if (err === 1'b1) n_err++;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %0t seen %h want %h", $time, s, e);
      end
   endtask
   task automatic complete_run;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tmo;
      n_fail++;
      $display("MISMATCH %0t timeout", $time);
      complete_run;
   endtask
   // Classic cycle: hold everything until ack is sampled high
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) tmo();
      q = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   function automatic logic [8:0] disp(input logic s, input logic [7:0] m);
      return {s, m};
   endfunction
   initial begin
      #100000;
      tmo();
   end
   initial begin
      logic [7:0] b1, x, y;
      int n;
      void'($urandom(32'h0480));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(4'h0, 32'h1);
      rd(4'h8, 32'h0);
      rd(4'h4, 32'h0);
      bus(1'b1, 4'hC, 32'hFF);
      rd(4'hC, 32'h8);
      rd(4'h2, 32'h0);
      // Good first byte, bad parity mid-packet, then bad stop: both bad bytes dropped
      u_mouse.send(8'h09, 1'b0, 1'b0);
      u_mouse.send(8'h55, 1'b1, 1'b0);
      u_mouse.send(8'h08, 1'b0, 1'b1);
      chk(n_err, 2);
      rd(4'h4, 32'h6);
      bus(1'b1, 4'h4, 32'h6);
      // Disabled receiver ignores even a bad frame
      bus(1'b1, 4'h0, 32'h0);
      rd(4'h0, 32'h0);
      u_mouse.send(8'h55, 1'b1, 1'b0);
      chk(n_err, 2);
      rd(4'h4, 32'h0);
      bus(1'b1, 4'h0, 32'h1);
      for (int i = 0; i < 8; i++) begin
         x = $urandom;
         y = $urandom;
         b1 = ($urandom & 8'hF3) | 8'h08;
         if (i == 0) {b1, x, y} = 24'hFBFF00;
         if (i == 1) {b1, x, y} = 24'h0800FF;
         if (i == 2) u_mouse.send(8'h00, 1'b0, 1'b0);
         bus(1'b1, 4'h8, i[0] ? 32'h0 : 32'h7);
         u_mouse.send(b1, 1'b0, 1'b0);
         u_mouse.send(x, 1'b0, 1'b0);
         u_mouse.send(y, 1'b0, 1'b0);
         n = 0;
         while (n_pkt != i + 1 && n < 100) begin
            @(posedge clk_i);
            n++;
         end
         if (n >= 100) tmo();
         chk({rb, lb}, b1[1:0]);
         chk({yo, xo, ys, xs}, b1[7:4]);
         chk({xm, ym}, {x, y});
         chk({xd, yd}, {disp(b1[4], x), disp(b1[5], y)});
         rd(4'hC, {8'h00, y, x, b1});
         chk(irq, !i[0]);
         rd(4'h4, 32'h1);
         bus(1'b1, 4'h4, 32'h1);
         #1 chk(irq, 1'b0);
      end
      chk(n_err, 2);
      complete_run;
   end
endmodule
`default_nettype wire
